//--- common/ahrf_defs.svh
// Offsets, bit positions, reset values and codes of the host task-file block.
`ifndef AHRF_DEFS_SVH
`define AHRF_DEFS_SVH
`define AHRF_SEL_DATA 4'h0
`define AHRF_SEL_FEAT 4'h1
`define AHRF_SEL_INTR 4'h2
`define AHRF_SEL_SCNT 4'h3
`define AHRF_SEL_BCL 4'h4
`define AHRF_SEL_BCH 4'h5
`define AHRF_SEL_DSEL 4'h6
`define AHRF_SEL_CMD 4'h7
`define AHRF_SEL_DCTL 4'h8
`define AHRF_SEL_DADR 4'h9
`define AHRF_SEL_NONE 4'hF
`define AHRF_SUB_ERR 4'h0
`define AHRF_SUB_INTR 4'h1
`define AHRF_SUB_SCNT 4'h2
`define AHRF_SUB_BCL 4'h3
`define AHRF_SUB_BCH 4'h4
`define AHRF_SUB_STAT 4'h5
`define AHRF_SUB_DADR 4'h6
`define AHRF_SUB_XCTL 4'h7
`define AHRF_SUB_FEAT 4'h8
`define AHRF_SUB_CMD 4'h9
`define AHRF_SUB_DSEL 4'hA
`define AHRF_DRV_BIT 4
`define AHRF_BSY_BIT 7
`define AHRF_SRST_BIT 2
`define AHRF_NIEN_BIT 1
`define AHRF_DADR_HIZ_BIT 7
`define AHRF_DIAG_CODE 8'h90
`define AHRF_DSEL_ONES 3'h7
`define AHRF_STAT_RST 8'h80
`define AHRF_DCTL_RST 8'h00
`endif

//--- common/ahrf_pkg.sv
// Types shared by the host task-file block.
package ahrf_pkg;
    typedef struct packed {
        logic cs1N;
        logic cs2N;
        logic [2:0] addr;
        logic rdN;
        logic wrN;
        logic [15:0] data;
    } ahrf_pins_s;
    typedef struct packed {
        logic we;
        logic [3:0] addr;
        logic [7:0] wdata;
    } ahrf_subreq_s;
    typedef struct packed {
        ahrf_pins_s s1;
        ahrf_pins_s s2;
        ahrf_pins_s s3;
        ahrf_pins_s filt;
        logic [7:0] features;
        logic [7:0] error;
        logic [7:0] intrReason;
        logic [7:0] sectorCount;
        logic [7:0] byteCountLow;
        logic [7:0] byteCountHigh;
        logic [7:0] driveSelect;
        logic [7:0] command;
        logic [7:0] status;
        logic [7:0] deviceControl;
        logic [7:0] driveAddress;
        logic ownDriveIdentity;
        logic hostIrqPend;
        logic cmdIrq;
        logic srstIrq;
        logic [1:0][15:0] wrBuf;
        logic wrHead;
        logic wrTail;
        logic [1:0] wrCount;
        logic [15:0] rdHold;
        logic rdFull;
        logic [15:0] dataOut;
        logic [15:0] dataOeN;
        logic irqOut;
        logic irqOeN;
        logic iordy;
        logic [7:0] subRdata;
        logic [15:0] subWrWord;
        logic subWrValid;
        logic subRdReady;
    } ahrf_state_s;
endpackage : ahrf_pkg

//--- rtl/ahrf_host_regs.sv
// Host-side task-file registers with data port, selection, command and interrupt logic.
`timescale 1ns/1ns
`include "ahrf_defs.svh"
// Function
// - Sixteen-bit data port moves words both ways.
// - Selected when host drive bit equals own.
// - Non-diagnostic commands, interrupt pin only while selected.
// - Selected command write raises command interrupt.
// - Diagnostic code raises command interrupt always.
// - Any command write clears host interrupt.
// - Busy set by command, diagnostic, soft reset, reset.
// - Alternate status reads leave interrupt untouched.
// - Drive address read floats data bit seven.
// - Soft reset bit raises interrupt, sets busy.
// - Interrupt pin driven only when enabled, selected.
// - Host and sub-processor share one register copy.
module ahrf_host_regs (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Host parallel bus.
    input wire logic hostCs1N,
    input wire logic hostCs2N,
    input wire logic [2:0] hostAddr,
    input wire logic hostRdN,
    input wire logic hostWrN,
    input wire logic [15:0] hostDataIn,
    output logic [15:0] hostDataOut,
    output logic [15:0] hostDataOeN,
    output logic hostIordy,
    output logic hostIrq,
    output logic hostIrqOeN,
    // Sub-processor register port.
    input wire ahrf_pkg::ahrf_subreq_s subReq,
    output logic [7:0] subRdata,
    input wire logic subHostIrqSet,
    input wire logic subXferActive,
    output logic cmdIrq,
    input wire logic cmdIrqAck,
    output logic srstIrq,
    input wire logic srstIrqAck,
    // Sub-processor data words.
    output logic [15:0] subWrWord,
    output logic subWrValid,
    input wire logic subWrReady,
    input wire logic [15:0] subRdWord,
    input wire logic subRdValid,
    output logic subRdReady
);
    import ahrf_pkg::*;

    ahrf_state_s st;
    ahrf_state_s next_st;

    function automatic logic [3:0] hostSel(input ahrf_pins_s p);
        if (!p.cs1N && p.cs2N) begin
            hostSel = {1'b0, p.addr};
        end else if (p.cs1N && !p.cs2N && p.addr == 3'h6) begin
            hostSel = `AHRF_SEL_DCTL;
        end else if (p.cs1N && !p.cs2N && p.addr == 3'h7) begin
            hostSel = `AHRF_SEL_DADR;
        end else begin
            hostSel = `AHRF_SEL_NONE;
        end
    endfunction : hostSel

    always_comb begin
        logic [3:0] sel;
        logic selected;
        logic wrEnd;
        logic rdStart;
        logic rdEnd;
        logic reading;
        logic cmdWr;
        logic cmdHit;
        logic srstHit;
        logic statRd;
        logic bufPush;
        logic bufPop;
        logic [15:0] rdWord;
        sel = `AHRF_SEL_NONE;
        selected = 1'b0;
        wrEnd = 1'b0;
        rdStart = 1'b0;
        rdEnd = 1'b0;
        reading = 1'b0;
        cmdWr = 1'b0;
        cmdHit = 1'b0;
        srstHit = 1'b0;
        statRd = 1'b0;
        bufPush = 1'b0;
        bufPop = 1'b0;
        rdWord = 16'h0000;
        next_st = st;
        next_st.s1 = {hostCs1N, hostCs2N, hostAddr, hostRdN, hostWrN, hostDataIn};
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < $bits(ahrf_pins_s); i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.filt[i] = st.s3[i];
            end
        end
        sel = hostSel(st.filt);
        selected = st.driveSelect[`AHRF_DRV_BIT] == st.ownDriveIdentity;
        wrEnd = !st.filt.wrN && next_st.filt.wrN;
        rdStart = st.filt.rdN && !next_st.filt.rdN;
        rdEnd = !st.filt.rdN && next_st.filt.rdN;
        reading = !st.filt.rdN && sel != `AHRF_SEL_NONE;
        // Host writes other than data, device control and drive address land in the shared copy that the sub-processor reads.
        if (wrEnd) begin
            case (sel)
                `AHRF_SEL_DATA: bufPush = subXferActive && st.wrCount != 2'd2;
                `AHRF_SEL_FEAT: next_st.features = st.filt.data[7:0];
                `AHRF_SEL_INTR: next_st.intrReason = st.filt.data[7:0];
                `AHRF_SEL_SCNT: next_st.sectorCount = st.filt.data[7:0];
                `AHRF_SEL_BCL: next_st.byteCountLow = st.filt.data[7:0];
                `AHRF_SEL_BCH: next_st.byteCountHigh = st.filt.data[7:0];
                `AHRF_SEL_DSEL: next_st.driveSelect = st.filt.data[7:0];
                `AHRF_SEL_CMD: cmdWr = 1'b1;
                `AHRF_SEL_DCTL: begin
                    next_st.deviceControl = st.filt.data[7:0];
                    srstHit = st.filt.data[`AHRF_SRST_BIT];
                end
                default: ;
            endcase
        end
        if (cmdWr) begin
            next_st.command = st.filt.data[7:0];
            cmdHit = selected || st.filt.data[7:0] == `AHRF_DIAG_CODE;
        end
        // The strobe edge and its chip select settle together, so decode the new address.
        statRd = rdStart && hostSel(next_st.filt) == `AHRF_SEL_CMD;
        // Sub-processor register writes.
        if (subReq.we) begin
            case (subReq.addr)
                `AHRF_SUB_ERR: next_st.error = subReq.wdata;
                `AHRF_SUB_INTR: next_st.intrReason = subReq.wdata;
                `AHRF_SUB_SCNT: next_st.sectorCount = subReq.wdata;
                `AHRF_SUB_BCL: next_st.byteCountLow = subReq.wdata;
                `AHRF_SUB_BCH: next_st.byteCountHigh = subReq.wdata;
                `AHRF_SUB_STAT: next_st.status = subReq.wdata;
                `AHRF_SUB_DADR: next_st.driveAddress = subReq.wdata;
                `AHRF_SUB_XCTL: next_st.ownDriveIdentity = subReq.wdata[0];
                default: ;
            endcase
        end
        if (cmdHit || srstHit) begin
            next_st.status[`AHRF_BSY_BIT] = 1'b1;
        end
        if (cmdIrqAck) begin
            next_st.cmdIrq = 1'b0;
        end
        if (cmdHit) begin
            next_st.cmdIrq = 1'b1;
        end
        if (srstIrqAck) begin
            next_st.srstIrq = 1'b0;
        end
        if (srstHit) begin
            next_st.srstIrq = 1'b1;
        end
        if (cmdWr || statRd) begin
            next_st.hostIrqPend = 1'b0;
        end
        if (subHostIrqSet) begin
            next_st.hostIrqPend = 1'b1;
        end
        // Two-entry buffer from host writes to the sub-processor.
        bufPop = st.subWrValid && subWrReady;
        if (bufPush) begin
            next_st.wrBuf[st.wrTail] = st.filt.data;
            next_st.wrTail = ~st.wrTail;
        end
        if (bufPop) begin
            next_st.wrHead = ~st.wrHead;
        end
        next_st.wrCount = st.wrCount + {1'b0, bufPush} - {1'b0, bufPop};
        next_st.subWrValid = next_st.wrCount != 2'd0;
        next_st.subWrWord = next_st.wrBuf[next_st.wrHead];
        next_st.iordy = next_st.wrCount != 2'd2;
        // Holding word from the sub-processor to host reads.
        if (rdEnd && sel == `AHRF_SEL_DATA && subXferActive) begin
            next_st.rdFull = 1'b0;
        end
        if (st.subRdReady && subRdValid) begin
            next_st.rdHold = subRdWord;
            next_st.rdFull = 1'b1;
        end
        next_st.subRdReady = !next_st.rdFull;
        case (sel)
            `AHRF_SEL_DATA: rdWord = st.rdHold;
            `AHRF_SEL_FEAT: rdWord = {8'h00, st.error};
            `AHRF_SEL_INTR: rdWord = {8'h00, st.intrReason};
            `AHRF_SEL_SCNT: rdWord = {8'h00, st.sectorCount};
            `AHRF_SEL_BCL: rdWord = {8'h00, st.byteCountLow};
            `AHRF_SEL_BCH: rdWord = {8'h00, st.byteCountHigh};
            `AHRF_SEL_DSEL: rdWord = {8'h00, `AHRF_DSEL_ONES, st.driveSelect[4:0]};
            `AHRF_SEL_CMD: rdWord = {8'h00, st.status};
            `AHRF_SEL_DCTL: rdWord = {8'h00, st.status};
            `AHRF_SEL_DADR: rdWord = {8'h00, st.driveAddress};
            default: rdWord = 16'h0000;
        endcase
        next_st.dataOut = rdWord;
        next_st.dataOeN = reading ? 16'h0000 : 16'hFFFF;
        if (reading && sel == `AHRF_SEL_DADR) begin
            next_st.dataOeN[`AHRF_DADR_HIZ_BIT] = 1'b1;
        end
        next_st.irqOut = st.hostIrqPend;
        next_st.irqOeN = !(!st.deviceControl[`AHRF_NIEN_BIT] && selected);
        case (subReq.addr)
            `AHRF_SUB_ERR: next_st.subRdata = st.error;
            `AHRF_SUB_INTR: next_st.subRdata = st.intrReason;
            `AHRF_SUB_SCNT: next_st.subRdata = st.sectorCount;
            `AHRF_SUB_BCL: next_st.subRdata = st.byteCountLow;
            `AHRF_SUB_BCH: next_st.subRdata = st.byteCountHigh;
            `AHRF_SUB_STAT: next_st.subRdata = st.status;
            `AHRF_SUB_DADR: next_st.subRdata = st.driveAddress;
            `AHRF_SUB_XCTL: next_st.subRdata = {7'h00, st.ownDriveIdentity};
            `AHRF_SUB_FEAT: next_st.subRdata = st.features;
            `AHRF_SUB_CMD: next_st.subRdata = st.command;
            `AHRF_SUB_DSEL: next_st.subRdata = st.driveSelect;
            default: next_st.subRdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.s1 <= '1;
            st.s2 <= '1;
            st.s3 <= '1;
            st.filt <= '1;
            st.status <= `AHRF_STAT_RST;
            st.deviceControl <= `AHRF_DCTL_RST;
            st.dataOeN <= 16'hFFFF;
            st.irqOeN <= 1'b1;
            st.iordy <= 1'b1;
            st.subRdReady <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign hostDataOut = st.dataOut;
    assign hostDataOeN = st.dataOeN;
    assign hostIordy = st.iordy;
    assign hostIrq = st.irqOut;
    assign hostIrqOeN = st.irqOeN;
    assign subRdata = st.subRdata;
    assign cmdIrq = st.cmdIrq;
    assign srstIrq = st.srstIrq;
    assign subWrWord = st.subWrWord;
    assign subWrValid = st.subWrValid;
    assign subRdReady = st.subRdReady;
endmodule : ahrf_host_regs

//--- test/ahrf_host_regs_monitor.sv
// Port-level assertions for the host task-file block.
`timescale 1ns/1ns
module ahrf_host_regs_monitor (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Host bus.
    input wire logic hostCs1N,
    input wire logic hostCs2N,
    input wire logic [2:0] hostAddr,
    input wire logic hostRdN,
    input wire logic hostWrN,
    input wire logic [15:0] hostDataIn,
    input wire logic [15:0] hostDataOeN,
    input wire logic hostIordy,
    input wire logic hostIrq,
    input wire logic hostIrqOeN,
    // Sub-processor side.
    input wire logic subHostIrqSet,
    input wire logic cmdIrq,
    input wire logic srstIrq,
    input wire logic [15:0] subWrWord,
    input wire logic subWrValid,
    input wire logic subWrReady
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence addrRead;
        !hostRdN && hostCs1N && !hostCs2N && hostAddr == 3'h7;
    endsequence
    reset_idle_a: assert property ($rose(nrst) |-> &hostDataOeN && hostIrqOeN
        && !cmdIrq && !srstIrq && !subWrValid) else $error("not idle after reset");
    cmd_cause_a: assert property ($rose(cmdIrq) |-> !$past(hostWrN, 7)
        && !$past(hostCs1N, 7) && $past(hostAddr, 7) == 3'h7) else $error("stray command");
    srst_cause_a: assert property ($rose(srstIrq) |-> !$past(hostWrN, 7)
        && !$past(hostCs2N, 7) && $past(hostDataIn[2], 7)) else $error("stray soft reset");
    irq_clear_a: assert property ($rose(cmdIrq) && !subHostIrqSet |=> !hostIrq)
        else $error("host interrupt kept");
    iordy_full_a: assert property (!hostIordy |-> subWrValid)
        else $error("not ready while empty");
    word_hold_a: assert property (subWrValid && !subWrReady |=>
        subWrValid && $stable(subWrWord)) else $error("word lost in stall");
    bus_release_a: assert property (hostRdN [*8] |-> &hostDataOeN)
        else $error("bus driven without read");
    addr_float_a: assert property (addrRead [*2] |-> hostDataOeN[7])
        else $error("bit 7 driven");
    cover property ($rose(cmdIrq));
    cover property ($rose(srstIrq));
    cover property (subWrValid && subWrReady);
endmodule : ahrf_host_regs_monitor
bind ahrf_host_regs ahrf_host_regs_monitor ahrf_host_regs_monitor_i (.core_clk, .nrst, .hostCs1N,
    .hostCs2N, .hostAddr, .hostRdN, .hostWrN, .hostDataIn, .hostDataOeN, .hostIordy, .hostIrq,
    .hostIrqOeN, .subHostIrqSet, .cmdIrq, .srstIrq, .subWrWord, .subWrValid, .subWrReady);

//--- test/ahrf_host_model.sv
// Behavioural host controller on the parallel task-file bus.
`timescale 1ns/1ns
module ahrf_host_model (
    // Clock and device drive.
    input wire logic core_clk,
    input wire logic [15:0] hostDataOut,
    input wire logic [15:0] hostDataOeN,
    // Host drive.
    output logic hostCs1N,
    output logic hostCs2N,
    output logic [2:0] hostAddr,
    output logic hostRdN,
    output logic hostWrN,
    output logic [15:0] hostDataIn
);
    logic drv = 1'b0;
    logic [15:0] wdat = 16'h0000;
    assign hostDataIn = (~hostDataOeN & hostDataOut) | (hostDataOeN & (drv ? wdat : ~wdat));
    initial begin
        {hostCs1N, hostCs2N, hostRdN, hostWrN, hostAddr} = 7'h78;
    end
    task automatic acc(input logic cs2, input logic [2:0] a, input logic w,
        input logic [15:0] wd, output logic [15:0] rd, output logic [15:0] oe);
        @(negedge core_clk);
        {hostCs1N, hostCs2N, hostAddr, drv, wdat} = {cs2, !cs2, a, w, wd};
        {hostWrN, hostRdN} = {!w, w};
        repeat (8) @(negedge core_clk);
        {rd, oe} = {hostDataOut, hostDataOeN};
        {hostWrN, hostRdN} = 2'h3;
        repeat (8) @(negedge core_clk);
        {hostCs1N, hostCs2N, drv} = 3'h6;
    endtask : acc
endmodule : ahrf_host_model

//--- test/test_ahrf_host_regs.sv
// Random self-checking bench of the host task-file block.
`timescale 1ns/1ns
module test_ahrf_host_regs;
    import ahrf_pkg::*;
    logic core_clk = 1'b0, nrst = 1'b0, hostCs1N, hostCs2N, hostRdN, hostWrN, hostIordy;
    logic hostIrq, hostIrqOeN, cmdIrq, srstIrq, subWrValid, subRdReady, subWrReady = 1'b0;
    logic subHostIrqSet = 1'b0, subXferActive = 1'b0, cmdIrqAck = 1'b0, srstIrqAck = 1'b0;
    logic subRdValid = 1'b0;
    logic [2:0] hostAddr;
    logic [15:0] hostDataIn, hostDataOut, hostDataOeN, subWrWord, rd, oe, v;
    logic [7:0] subRdata;
    logic [15:0] subRdWord = 16'h0000;
    logic [15:0] ws[3];
    logic [15:0] got[$];
    ahrf_subreq_s subReq = '0;
    int n_fail = 0, n_compared = 0, cycles = 0, seed = 32'h15e3;
    ahrf_host_regs ahrf_host_regs_i (.core_clk, .nrst, .hostCs1N, .hostCs2N, .hostAddr,
        .hostRdN, .hostWrN, .hostDataIn, .hostDataOut, .hostDataOeN, .hostIordy, .hostIrq,
        .hostIrqOeN, .subReq, .subRdata, .subHostIrqSet, .subXferActive, .cmdIrq, .cmdIrqAck,
        .srstIrq, .srstIrqAck, .subWrWord, .subWrValid, .subWrReady, .subRdWord, .subRdValid,
        .subRdReady);
    ahrf_host_model host_i (.core_clk, .hostDataOut, .hostDataOeN, .hostCs1N, .hostCs2N,
        .hostAddr, .hostRdN, .hostWrN, .hostDataIn);
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (subWrValid && subWrReady) got.push_back(subWrWord);
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic due(input logic sel, input logic [7:0] code);
        return sel || code == 8'h90;
    endfunction : due
    task automatic hb(input logic cs2, input logic [2:0] a, input logic w, input logic [15:0] d);
        host_i.acc(cs2, a, w, d, rd, oe);
    endtask : hb
    task automatic sub_clear;
        @(negedge core_clk);
        {cmdIrqAck, srstIrqAck, subReq} = {2'h3, 1'b1, 4'h5, 8'h00};
        @(negedge core_clk);
        {cmdIrqAck, srstIrqAck, subReq} = '0;
    endtask : sub_clear
    task automatic sub_acc(input logic we, input logic [3:0] a, input logic [7:0] d);
        @(negedge core_clk);
        subReq = {we, a, d};
        @(negedge core_clk);
        subReq.we = 1'b0;
    endtask : sub_acc
    task automatic irq_pulse;
        @(negedge core_clk) subHostIrqSet = 1'b1;
        @(negedge core_clk) subHostIrqSet = 1'b0;
        @(negedge core_clk);
    endtask : irq_pulse
    initial begin
        repeat (8) @(negedge core_clk);
        nrst = 1'b1;
        hb(0, 7, 0, 0);
        check("status", rd, 16'h0080);
        sub_clear();
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            v[4] = i[0];
            hb(0, 6, 1, v);
            hb(1, 6, 1, {14'h0000, i[1], 1'b0});
            hb(0, 6, 0, 0);
            check("drive select", rd[7:4], {3'h7, v[4]});
            check("irq enable", hostIrqOeN, v[4] | i[1]);
            v = $random(seed);
            hb(0, 7, 1, v);
            check("cmd event", cmdIrq, due(!i[0], v[7:0]));
            hb(1, 6, 0, 0);
            check("busy", rd[7], due(!i[0], v[7:0]));
            sub_clear();
        end
        hb(0, 7, 1, 16'h0090);
        check("diag event", cmdIrq, 1'b1);
        hb(0, 6, 1, 0);
        hb(1, 6, 1, 0);
        irq_pulse();
        hb(1, 6, 0, 0);
        check("irq kept", {hostIrqOeN, hostIrq}, 2'h1);
        hb(0, 7, 0, 0);
        check("irq status read", hostIrq, 1'b0);
        irq_pulse();
        check("irq raised", hostIrq, 1'b1);
        hb(0, 7, 1, 0);
        check("irq cleared", hostIrq, 1'b0);
        sub_clear();
        hb(1, 6, 1, 16'h0004);
        check("soft reset", srstIrq, 1'b1);
        hb(1, 6, 0, 0);
        check("soft busy", rd[7], 1'b1);
        hb(1, 6, 1, 0);
        hb(1, 7, 0, 0);
        check("addr bit 7", oe[7], 1'b1);
        v = $random(seed);
        hb(0, 3, 1, v);
        sub_acc(0, 4'h2, 8'h00);
        check("shared count", subRdata, v[7:0]);
        sub_acc(1, 4'h0, v[15:8]);
        hb(0, 1, 0, 0);
        check("shared error", rd, {8'h00, v[15:8]});
        sub_clear();
        sub_acc(1, 4'h7, 8'h01);
        hb(0, 6, 1, 16'h0010);
        check("own identity", hostIrqOeN, 1'b0);
        hb(0, 7, 1, 16'h00a0);
        check("own cmd event", cmdIrq, 1'b1);
        hb(0, 6, 1, 0);
        check("other drive", hostIrqOeN, 1'b1);
        sub_acc(1, 4'h7, 8'h00);
        sub_clear();
        subXferActive = 1'b1;
        for (int i = 0; i < 3; i++) begin
            ws[i] = $random(seed);
            hb(0, 0, 1, ws[i]);
        end
        check("ready full", hostIordy, 1'b0);
        subWrReady = 1'b1;
        repeat (4) @(negedge core_clk);
        check("word count", 16'(got.size()), 16'h0002);
        check("word 0", got[0], ws[0]);
        check("word 1", got[1], ws[1]);
        subRdWord = $random(seed);
        subRdValid = 1'b1;
        @(posedge core_clk iff subRdReady);
        @(negedge core_clk) subRdValid = 1'b0;
        hb(0, 0, 0, 0);
        check("read word", rd, subRdWord);
        report_and_stop();
    end
endmodule : test_ahrf_host_regs
